// [dpc_pkg.sv]
// Purpose: Shared constants, types and helpers of the preset chain
// Assumes: 16-bit samples, 1.15 coefficients, AHB-Lite word access
// Notes: Register map, field layout and the preset table live here
`default_nettype none
package dpc_pkg;
	localparam int SW         = 16;
	localparam int NCH        = 2;
	localparam int NSTG       = 7;
	localparam int NCOEF      = 33;
	localparam int NCOEF_ALL  = 66;
	localparam int CIDX_W     = 7;
	localparam int AW         = 12;
	localparam int FRAC       = 15;
	localparam int ACC_W      = 36;
	localparam int IIR_NC     = 3;
	localparam int BQ_NC      = 5;
	localparam int BUF_DEPTH  = 2;
	localparam int BUF_W      = 32;
	localparam int DRC_SHIFT  = 2;
	localparam int OSC_SHIFT  = 14;
	// Register byte offsets
	localparam logic [AW-1:0] A_CTRL     = 12'h000;
	localparam logic [AW-1:0] A_STAT     = 12'h004;
	localparam logic [AW-1:0] A_BEEP     = 12'h008;
	localparam logic [AW-1:0] A_COEF     = 12'h100;
	localparam logic [AW-1:0] A_COEF_END = 12'h208;
	localparam logic [2:0]    SIZE_WORD  = 3'h2;
	// Field positions
	localparam int CTRL_PRESET = 0;
	localparam int PRESET_W    = 5;
	localparam int CTRL_RUN    = 8;
	localparam int CTRL_ADAPT  = 9;
	localparam int CTRL_BEEP   = 12;
	localparam int ST_FILT     = 0;
	localparam int ST_LEFT     = 2;
	localparam int ST_IIR      = 3;
	localparam int ST_NBQ      = 4;
	localparam int ST_DRC      = 7;
	localparam int ST_3D       = 8;
	localparam int ST_BEEP     = 9;
	localparam int ST_REFUSED  = 16;
	localparam int ST_BUSY     = 17;
	localparam int BEEP_COS    = 0;
	localparam int BEEP_AMP    = 16;
	// Reset values
	localparam logic [4:0]  PRESET_RST   = 5'h01;
	localparam logic [4:0]  PRESET_MAX   = 5'h19;
	localparam logic [15:0] N0_RST       = 16'h7fff;
	localparam logic [15:0] DRC_THR      = 16'h4000;
	localparam logic [15:0] BEEP_COS_RST = 16'h7d8a;
	localparam logic [15:0] BEEP_AMP_RST = 16'h0800;
	localparam logic signed [ACC_W-1:0] SAT_HI = 36'sh0_0000_7fff;
	localparam logic signed [ACC_W-1:0] SAT_LO = 36'shf_ffff_8000;

	typedef enum logic [1:0] {FILT_A, FILT_B, FILT_C} dpc_filt_t;
	typedef struct packed {
		dpc_filt_t  filt;
		logic       left_only;
		logic       iir;
		logic [2:0] nbq;
		logic       dynamic_range_compression;
		logic       d3;
		logic       beep;
	} dpc_cfg_t;

	function automatic dpc_cfg_t dpc_preset_cfg(input logic [4:0] p_in);
		logic [4:0] p;
		dpc_cfg_t   c;
		p = (p_in == 5'h00 || p_in > PRESET_MAX) ? PRESET_RST : p_in;
		c.filt = (p >= 5'h17) ? FILT_A : (p >= 5'h11) ? FILT_C :
			(p >= 5'h07) ? FILT_B : FILT_A;
		c.left_only = p inside {5'h04, 5'h05, 5'h06, 5'h0c, 5'h0d, 5'h0e,
			5'h0f, 5'h10, 5'h14, 5'h15, 5'h16};
		c.iir = !(p inside {5'h01, 5'h04, 5'h08, 5'h09, 5'h0d, 5'h0e,
			5'h17});
		c.dynamic_range_compression = p inside {5'h02, 5'h05, 5'h08, 5'h0a, 5'h0d, 5'h0f, 5'h12,
			5'h15, 5'h18, 5'h19};
		c.d3 = p inside {5'h17, 5'h18, 5'h19};
		c.beep = (p == 5'h19);
		case (p)
			5'h02, 5'h05, 5'h0a, 5'h0f: c.nbq = 3'h6;
			5'h03, 5'h06, 5'h0b, 5'h10: c.nbq = 3'h6;
			5'h07, 5'h0c, 5'h11, 5'h14: c.nbq = 3'h0;
			5'h08, 5'h0d: c.nbq = 3'h4;
			5'h09, 5'h0e: c.nbq = 3'h4;
			5'h12, 5'h15: c.nbq = 3'h4;
			5'h13, 5'h16: c.nbq = 3'h4;
			5'h17: c.nbq = 3'h2;
			5'h18: c.nbq = 3'h5;
			5'h19: c.nbq = 3'h5;
			default: c.nbq = 3'h3;
		endcase
		return c;
	endfunction : dpc_preset_cfg

	function automatic logic signed [SW-1:0] dpc_sat(
		input logic signed [ACC_W-1:0] v);
		return (v > SAT_HI) ? 16'sh7fff : (v < SAT_LO) ? 16'sh8000 : v[SW-1:0];
	endfunction : dpc_sat

	function automatic logic [SW-1:0] dpc_coef_rst(input int i);
		int l;
		l = i % NCOEF;
		return (l == 0 || (l >= IIR_NC && (l - IIR_NC) % BQ_NC == 0))
			? N0_RST : '0;
	endfunction : dpc_coef_rst

	function automatic logic dpc_is_coef(input logic [AW-1:0] a);
		return a >= A_COEF && a < A_COEF_END && a[1:0] == 2'h0;
	endfunction : dpc_is_coef

	function automatic logic [CIDX_W-1:0] dpc_coef_idx(input logic [AW-1:0] a);
		logic [AW-1:0] d;
		d = a - A_COEF;
		return d[CIDX_W+1:2];
	endfunction : dpc_coef_idx
endpackage : dpc_pkg
`default_nettype wire

// [dpc_buf_if.sv]
// Purpose: Valid/ready carrier between the chain and its output buffer
// Assumes: One clock, transfer when valid and ready are both high
// Notes: Filling side, buffer side and draining side each have a modport
`default_nettype none
interface dpc_buf_if #(parameter int W = dpc_pkg::BUF_W);
	logic         in_valid;
	logic         in_ready;
	logic [W-1:0] in_data;
	logic         out_valid;
	logic         out_ready;
	logic [W-1:0] out_data;
	modport fill   (output in_valid, output in_data, input in_ready);
	modport buffer (input in_valid, input in_data, output in_ready,
		output out_valid, output out_data, input out_ready);
	modport drain  (input out_valid, input out_data, output out_ready);
endinterface : dpc_buf_if
`default_nettype wire

// [dpc_skid_buf.sv]
// Purpose: Small shift-queue buffer on the sample output path
// Assumes: Head entry is the output, so data and valid come from flops
// Notes: in_ready is low only while every entry is full
`default_nettype none
module dpc_skid_buf #(
	parameter int W     = dpc_pkg::BUF_W,
	parameter int DEPTH = dpc_pkg::BUF_DEPTH
) (
	input wire logic clk,
	input wire logic rst_n,
	dpc_buf_if.buffer b
);
	logic [W-1:0]     mem      [DEPTH];
	logic [W-1:0]     next_mem [DEPTH];
	logic [DEPTH-1:0] vld;
	logic [DEPTH-1:0] next_vld;
	logic [DEPTH-1:0] sv;
	logic [DEPTH-1:0] pv;

	wire push = b.in_valid & b.in_ready;
	wire pop  = b.out_valid & b.out_ready;
	assign b.in_ready  = ~vld[DEPTH-1];
	assign b.out_valid = vld[0];
	assign b.out_data  = mem[0];
	// Occupancy after the pop, and whether the slot below is filled
	assign sv = pop ? {1'b0, vld[DEPTH-1:1]} : vld;
	assign pv = {sv[DEPTH-2:0], 1'b1};

	for (genvar i = 0; i < DEPTH; i++) begin : g_ent
		wire here = push & ~sv[i] & pv[i];
		logic [W-1:0] up;
		if (i < DEPTH - 1) begin : g_up
			assign up = mem[i+1];
		end else begin : g_top
			assign up = mem[i];
		end
		assign next_vld[i] = sv[i] | here;
		assign next_mem[i] = here ? b.in_data : (pop ? up : mem[i]);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			vld <= '0;
			for (int i = 0; i < DEPTH; i++) mem[i] <= '0;
		end else begin
			vld <= next_vld;
			for (int i = 0; i < DEPTH; i++) mem[i] <= next_mem[i];
		end
	end
endmodule : dpc_skid_buf
`default_nettype wire

// [dpc_chain.sv]
// Purpose: Preset-selected DAC processing chain with AHB-Lite registers
// Assumes: Samples synchronous to hclk, one engine shared by both channels
// Notes: Stages run one per cycle; output passes a two-entry buffer
`default_nettype none
// Operation
// - Selected preset decides stages and interpolation filter
// - IIR and biquad coefficients are host programmable
// - Presets 1,4: three biquads, filter A
// - Presets 2,5,10,15: IIR, six biquads, compression
// - Presets 3,6,11,16: IIR, six biquads only
// - Presets 7,12,17,20: IIR only, no biquads
// - Presets 8,13: four biquads, compression, filter B
// - Presets 9,14: four biquads, filter B
// - Presets 18,21: IIR, four biquads, compression, C
// - Presets 19,22: IIR, four biquads, filter C
// - Preset 23: two biquads, 3D, filter A
// - Preset 24: IIR, five biquads, compression, 3D
// - Preset 25 adds tone generator, only one
// - Coefficients are 16-bit 1.15 two's complement
// - Coefficient access refused while running, non-adaptive
module dpc_chain (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        in_valid,
	output logic             in_ready,
	input  wire logic [15:0] in_left,
	input  wire logic [15:0] in_right,
	output logic             out_valid,
	input  wire logic        out_ready,
	output logic      [15:0] out_left,
	output logic      [15:0] out_right,
	output logic      [1:0]  interp_filter
);
	typedef enum logic [2:0] {
		S_IDLE, S_IIR, S_BQ, S_DRC, S_3D, S_BEEP, S_PUSH
	} dpc_state_t;

	logic [4:0]         preset;
	logic               run;
	logic               adapt;
	logic               beep_en;
	logic signed [15:0] beep_cos;
	logic signed [15:0] beep_amp;
	logic               refused;
	logic signed [15:0] coef [dpc_pkg::NCOEF_ALL];
	logic               dp_wr;
	logic [11:0]        dp_addr;
	logic [31:0]        rd_val;
	dpc_state_t         state;
	dpc_state_t         next_state;
	dpc_pkg::dpc_cfg_t  cfg;
	logic [2:0]         bq_cnt;
	logic signed [15:0] smp [dpc_pkg::NCH];
	logic signed [15:0] hx1 [dpc_pkg::NCH][dpc_pkg::NSTG];
	logic signed [15:0] hx2 [dpc_pkg::NCH][dpc_pkg::NSTG];
	logic signed [15:0] hy1 [dpc_pkg::NCH][dpc_pkg::NSTG];
	logic signed [15:0] hy2 [dpc_pkg::NCH][dpc_pkg::NSTG];
	logic signed [15:0] res     [dpc_pkg::NCH];
	logic signed [15:0] drc_res [dpc_pkg::NCH];
	logic signed [15:0] d3_res  [dpc_pkg::NCH];
	logic signed [15:0] mix_res [dpc_pkg::NCH];
	logic signed [15:0] osc1;
	logic signed [15:0] osc2;
	dpc_buf_if #(.W(dpc_pkg::BUF_W)) bif ();

	// Bus decode
	wire        ap_valid = hsel & hready & htrans[1];
	wire [11:0] ap_addr  = haddr[11:0];
	wire        ap_coef  = dpc_pkg::dpc_is_coef(ap_addr);
	wire        dp_coef  = dpc_pkg::dpc_is_coef(dp_addr);
	wire [6:0]  ap_idx   = dpc_pkg::dpc_coef_idx(ap_addr);
	wire [6:0]  dp_idx   = dpc_pkg::dpc_coef_idx(dp_addr);
	wire        ap_rd    = ap_valid & ~hwrite;
	wire        locked   = run & ~adapt;
	wire        wr_ctrl  = dp_wr && dp_addr == dpc_pkg::A_CTRL;
	wire        wr_stat  = dp_wr && dp_addr == dpc_pkg::A_STAT;
	wire        wr_beep  = dp_wr && dp_addr == dpc_pkg::A_BEEP;
	wire        wr_coef  = dp_wr & dp_coef & ~locked;
	wire        refuse_now = locked & ((ap_rd & ap_coef) | (dp_wr & dp_coef));
	wire        clr_ref  = wr_stat & hwdata[dpc_pkg::ST_REFUSED];

	// Engine decode
	wire dpc_pkg::dpc_cfg_t sel_cfg = dpc_pkg::dpc_preset_cfg(preset);
	wire       take     = in_valid & in_ready;
	wire       next_run = wr_ctrl ? hwdata[dpc_pkg::CTRL_RUN] : run;
	wire       is_iir   = (state == S_IIR);
	wire       stage_en = (is_iir & cfg.iir) | (state == S_BQ);
	wire [2:0] stg      = is_iir ? 3'h0 : 3'(bq_cnt + 3'h1);
	wire [6:0] base     = is_iir ? 7'h0 : 7'(dpc_pkg::IIR_NC +
		dpc_pkg::BQ_NC * int'(bq_cnt));
	wire [0:0] dbl      = ~is_iir;
	wire       beep_on  = cfg.beep & beep_en;
	wire signed [16:0] dl = 17'(smp[0]);
	wire signed [16:0] dr = 17'(smp[1]);
	wire signed [16:0] diff = (dl - dr) >>> 1;
	wire signed [16:0] thr = 17'(dpc_pkg::DRC_THR);
	wire signed [16:0] osc_w = 17'(osc1);
	wire signed [31:0] osc_p = beep_cos * osc1;
	wire signed [15:0] osc_next = dpc_pkg::dpc_sat(
		(36'(osc_p) >>> dpc_pkg::OSC_SHIFT) - 36'(osc2));

	for (genvar ch = 0; ch < dpc_pkg::NCH; ch++) begin : g_mac
		localparam logic [6:0] CB = 7'(ch * dpc_pkg::NCOEF);
		wire [6:0] b = CB + base;
		wire signed [15:0] cn0 = coef[b];
		wire signed [15:0] cn1 = coef[b + 7'h1];
		wire signed [15:0] cn2 = is_iir ? 16'sh0 : coef[b + 7'h2];
		wire signed [15:0] cd1 = is_iir ? coef[b + 7'h2] : coef[b + 7'h3];
		wire signed [15:0] cd2 = is_iir ? 16'sh0 : coef[b + 7'h4];
		wire signed [31:0] p0 = cn0 * smp[ch];
		wire signed [31:0] p1 = cn1 * hx1[ch][stg];
		wire signed [31:0] p2 = cn2 * hx2[ch][stg];
		wire signed [31:0] p3 = cd1 * hy1[ch][stg];
		wire signed [31:0] p4 = cd2 * hy2[ch][stg];
		// Doubled N1 and D1 terms apply to biquads only
		wire signed [35:0] acc = 36'(p0) + 36'(p2) + 36'(p4) +
			((36'(p1) + 36'(p3)) <<< dbl);
		wire signed [16:0] xs = 17'(smp[ch]);
		wire signed [16:0] sd = (ch == 0) ? diff : -diff;
		assign res[ch] = dpc_pkg::dpc_sat(acc >>> dpc_pkg::FRAC);
		// Above threshold the excess is scaled down
		assign drc_res[ch] = (xs > thr) ?
			16'(thr + ((xs - thr) >>> dpc_pkg::DRC_SHIFT)) : (xs < -thr) ?
			16'(-thr + ((xs + thr) >>> dpc_pkg::DRC_SHIFT)) : smp[ch];
		assign d3_res[ch] = dpc_pkg::dpc_sat(36'(xs + sd));
		assign mix_res[ch] = dpc_pkg::dpc_sat(36'(xs + osc_w));
	end

	// Register read mux
	always_comb begin
		rd_val = '0;
		if (ap_coef) begin
			if (!locked) begin
				rd_val[15:0] = coef[ap_idx];
			end
		end else if (ap_addr == dpc_pkg::A_CTRL) begin
			rd_val[dpc_pkg::CTRL_PRESET +: dpc_pkg::PRESET_W] = preset;
			rd_val[dpc_pkg::CTRL_RUN]   = run;
			rd_val[dpc_pkg::CTRL_ADAPT] = adapt;
			rd_val[dpc_pkg::CTRL_BEEP]  = beep_en;
		end else if (ap_addr == dpc_pkg::A_STAT) begin
			rd_val[dpc_pkg::ST_FILT +: 2] = sel_cfg.filt;
			rd_val[dpc_pkg::ST_LEFT]      = sel_cfg.left_only;
			rd_val[dpc_pkg::ST_IIR]       = sel_cfg.iir;
			rd_val[dpc_pkg::ST_NBQ +: 3]  = sel_cfg.nbq;
			rd_val[dpc_pkg::ST_DRC]       = sel_cfg.dynamic_range_compression;
			rd_val[dpc_pkg::ST_3D]        = sel_cfg.d3;
			rd_val[dpc_pkg::ST_BEEP]      = sel_cfg.beep;
			rd_val[dpc_pkg::ST_REFUSED]   = refused;
			rd_val[dpc_pkg::ST_BUSY]      = (state != S_IDLE);
		end else if (ap_addr == dpc_pkg::A_BEEP) begin
			rd_val[dpc_pkg::BEEP_COS +: 16] = beep_cos;
			rd_val[dpc_pkg::BEEP_AMP +: 16] = beep_amp;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr     <= 1'b0;
			dp_addr   <= '0;
			hrdata    <= '0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			dp_wr   <= ap_valid & hwrite & (hsize == dpc_pkg::SIZE_WORD);
			dp_addr <= ap_addr;
			if (ap_rd) begin
				hrdata <= rd_val;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			preset   <= dpc_pkg::PRESET_RST;
			run      <= 1'b0;
			adapt    <= 1'b0;
			beep_en  <= 1'b0;
			beep_cos <= dpc_pkg::BEEP_COS_RST;
			beep_amp <= dpc_pkg::BEEP_AMP_RST;
			refused  <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				preset  <= hwdata[dpc_pkg::CTRL_PRESET +: dpc_pkg::PRESET_W];
				run     <= hwdata[dpc_pkg::CTRL_RUN];
				adapt   <= hwdata[dpc_pkg::CTRL_ADAPT];
				beep_en <= hwdata[dpc_pkg::CTRL_BEEP];
			end
			if (wr_beep) begin
				beep_cos <= hwdata[dpc_pkg::BEEP_COS +: 16];
				beep_amp <= hwdata[dpc_pkg::BEEP_AMP +: 16];
			end
			// A new refusal outweighs a clear in the same cycle
			refused <= refuse_now | (refused & ~clr_ref);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < dpc_pkg::NCOEF_ALL; i++) begin
				coef[i] <= dpc_pkg::dpc_coef_rst(i);
			end
		end else if (wr_coef) begin
			coef[dp_idx] <= hwdata[15:0];
		end
	end

	// Sequencer
	always_comb begin
		next_state = state;
		case (state)
			S_IDLE: if (take) next_state = S_IIR;
			S_IIR:  next_state = (cfg.nbq == 3'h0) ? S_DRC : S_BQ;
			S_BQ:   if (bq_cnt == 3'(cfg.nbq - 3'h1)) next_state = S_DRC;
			S_DRC:  next_state = S_3D;
			S_3D:   next_state = S_BEEP;
			S_BEEP: next_state = S_PUSH;
			S_PUSH: if (bif.in_ready) next_state = S_IDLE;
			default: next_state = S_IDLE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state         <= S_IDLE;
			cfg           <= '0;
			bq_cnt        <= '0;
			in_ready      <= 1'b0;
			interp_filter <= '0;
		end else begin
			state         <= next_state;
			in_ready      <= (next_state == S_IDLE) & next_run;
			interp_filter <= sel_cfg.filt;
			bq_cnt        <= (state == S_BQ) ? 3'(bq_cnt + 3'h1) : 3'h0;
			if (take) begin
				cfg <= sel_cfg;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int c = 0; c < dpc_pkg::NCH; c++) begin
				smp[c] <= '0;
				for (int s = 0; s < dpc_pkg::NSTG; s++) begin
					hx1[c][s] <= '0;
					hx2[c][s] <= '0;
					hy1[c][s] <= '0;
					hy2[c][s] <= '0;
				end
			end
		end else begin
			for (int c = 0; c < dpc_pkg::NCH; c++) begin
				if (take) begin
					smp[c] <= (c == 0) ? in_left :
						(sel_cfg.left_only ? 16'sh0 : in_right);
				end else if (c == 0 || !cfg.left_only) begin
					if (stage_en) begin
						hx2[c][stg] <= hx1[c][stg];
						hx1[c][stg] <= smp[c];
						hy2[c][stg] <= hy1[c][stg];
						hy1[c][stg] <= res[c];
						smp[c]      <= res[c];
					end else if (state == S_DRC && cfg.dynamic_range_compression) begin
						smp[c] <= drc_res[c];
					end else if (state == S_3D && cfg.d3) begin
						smp[c] <= d3_res[c];
					end else if (state == S_BEEP && beep_on) begin
						smp[c] <= mix_res[c];
					end
				end
			end
		end
	end

	// Tone oscillator restarts from the programmed kick while beep_on is low
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			osc1 <= '0;
			osc2 <= '0;
		end else if (!beep_on) begin
			osc1 <= '0;
			osc2 <= -beep_amp;
		end else if (state == S_BEEP) begin
			osc1 <= osc_next;
			osc2 <= osc1;
		end
	end

	assign bif.in_valid  = (state == S_PUSH);
	assign bif.in_data   = {smp[1], smp[0]};
	assign bif.out_ready = out_ready;
	assign out_valid     = bif.out_valid;
	assign out_left      = bif.out_data[15:0];
	assign out_right     = bif.out_data[31:16];

	dpc_skid_buf #(
		.W     (dpc_pkg::BUF_W),
		.DEPTH (dpc_pkg::BUF_DEPTH)
	) u_buf (
		.clk   (hclk),
		.rst_n (hresetn),
		.b     (bif.buffer)
	);

	property p_ready_idle;
		@(posedge hclk) disable iff (!hresetn)
		in_ready |-> state == S_IDLE && run;
	endproperty
	a_ready_idle: assert property (p_ready_idle)
		else $error("input ready outside idle");

	property p_cfg_latch;
		@(posedge hclk) disable iff (!hresetn)
		take |=> cfg == $past(sel_cfg) && state == S_IIR;
	endproperty
	a_cfg_latch: assert property (p_cfg_latch)
		else $error("preset not latched at sample start");

	property p_coef_write;
		@(posedge hclk) disable iff (!hresetn)
		wr_coef |=> coef[$past(dp_idx)] == $past(hwdata[15:0]);
	endproperty
	a_coef_write: assert property (p_coef_write)
		else $error("coefficient write lost");

	property p_refuse_rd;
		@(posedge hclk) disable iff (!hresetn)
		ap_rd && ap_coef && locked |=> hrdata == 32'h0 && refused;
	endproperty
	a_refuse_rd: assert property (p_refuse_rd)
		else $error("locked coefficient read not refused");

	property p_refuse_wr;
		@(posedge hclk) disable iff (!hresetn)
		dp_wr && dp_coef && locked |=> refused
			&& coef[$past(dp_idx)] == $past(coef[dp_idx]);
	endproperty
	a_refuse_wr: assert property (p_refuse_wr)
		else $error("locked coefficient write not refused");

	property p_right_quiet;
		@(posedge hclk) disable iff (!hresetn)
		state == S_PUSH && cfg.left_only |-> smp[1] == 16'sh0;
	endproperty
	a_right_quiet: assert property (p_right_quiet)
		else $error("right channel processed in left-only preset");

	property p_three_bq;
		@(posedge hclk) disable iff (!hresetn)
		take && preset inside {5'h01, 5'h04} |=> !cfg.iir && !cfg.dynamic_range_compression
			&& state == S_IIR ##1 state == S_BQ [*3] ##1 state == S_DRC;
	endproperty
	a_three_bq: assert property (p_three_bq)
		else $error("three-biquad chain wrong");

	property p_six_bq;
		@(posedge hclk) disable iff (!hresetn)
		take && preset inside {5'h03, 5'h06, 5'h0b, 5'h10} |=> cfg.iir
			&& !cfg.dynamic_range_compression ##1 state == S_BQ [*6] ##1 state == S_DRC;
	endproperty
	a_six_bq: assert property (p_six_bq)
		else $error("six-biquad chain wrong");

	property p_iir_only;
		@(posedge hclk) disable iff (!hresetn)
		take && preset inside {5'h07, 5'h0c, 5'h11, 5'h14} |=> cfg.iir
			##1 state == S_DRC;
	endproperty
	a_iir_only: assert property (p_iir_only)
		else $error("IIR-only chain runs biquads");

	property p_beep_only25;
		@(posedge hclk) disable iff (!hresetn)
		take && preset != dpc_pkg::PRESET_MAX |=> !cfg.beep;
	endproperty
	a_beep_only25: assert property (p_beep_only25)
		else $error("tone generator outside its preset");

	c_beep: cover property (@(posedge hclk) disable iff (!hresetn)
		state == S_BEEP && beep_on);
	c_refused: cover property (@(posedge hclk) disable iff (!hresetn)
		refuse_now);
	c_stall: cover property (@(posedge hclk) disable iff (!hresetn)
		state == S_PUSH && !bif.in_ready);
	c_left_out: cover property (@(posedge hclk) disable iff (!hresetn)
		take && sel_cfg.left_only);
endmodule : dpc_chain
`default_nettype wire

// [dpc_sink.sv]
// Purpose: Modulator-side sink that pops processed sample pairs
// Assumes: Pops on valid and ready at a rising edge
// Notes: Stall input lets the bench hold the output path back
`default_nettype none
module dpc_sink (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        stall,
	input  wire logic        valid,
	input  wire logic [15:0] left,
	input  wire logic [15:0] right,
	output logic             ready,
	output int               count,
	output logic      [15:0] last_l,
	output logic      [15:0] last_r
);
	assign ready = !stall;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count  <= 0;
			last_l <= '0;
			last_r <= '0;
		end else if (valid && ready) begin
			count  <= count + 1;
			last_l <= left;
			last_r <= right;
		end
	end
endmodule : dpc_sink
`default_nettype wire

// [dpc_chain_test.sv]
// Purpose: Self-checking bench of the preset processing chain
// Assumes: Zero-wait AHB-Lite slave, run bit gates the sample stream
// Notes: Expected preset fields come from tables written here
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
	failures++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module dpc_chain_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
	logic        in_valid = 0, stall = 0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
	logic [1:0]  htrans = '0, interp_filter;
	logic [2:0]  hsize = 3'h2;
	logic [15:0] in_left = '0, in_right = '0, out_left, out_right, sl, sr;
	logic        hreadyout, hresp, in_ready, out_valid, out_ready;
	int          failures = 0, cmp_count = 0, cyc = 0, got;

	dpc_chain i_dpc_chain (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
		.in_valid, .in_ready, .in_left, .in_right, .out_valid, .out_ready,
		.out_left, .out_right, .interp_filter);
	dpc_sink i_dpc_sink (.clk(hclk), .rst_n(hresetn), .stall, .valid(out_valid),
		.left(out_left), .right(out_right), .ready(out_ready), .count(got),
		.last_l(sl), .last_r(sr));

	always #2 hclk = ~hclk;
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			wrap_up();
		end
	end

	task automatic bw(input logic [11:0] a, input logic [31:0] d);
		@(posedge hclk);
		{hsel, hwrite, htrans, haddr} <= {2'b11, 2'h2, 20'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		{hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask : bw

	task automatic br(input logic [11:0] a, output logic [31:0] d);
		@(posedge hclk);
		{hsel, hwrite, htrans, haddr} <= {2'b10, 2'h2, 20'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		{hsel, htrans} <= {1'b0, 2'h0};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		d = hrdata;
	endtask : br

	task automatic send(input logic [15:0] l, input logic [15:0] r);
		@(posedge hclk);
		{in_valid, in_left, in_right} <= {1'b1, l, r};
		do @(posedge hclk); while (in_ready !== 1'b1);
		in_valid <= 1'b0;
	endtask : send

	task automatic wait_out(input int n);
		for (int i = 0; i < 100 && got < n; i++) @(posedge hclk);
		`CHK("pops", n, got)
	endtask : wait_out

	task automatic t_reset;
		br(12'h000, rd);
		`CHK("ctrl", 32'h0000_0001, rd)
		br(12'h008, rd);
		`CHK("beep", 32'h0800_7d8a, rd)
		br(12'h100, rd);
		`CHK("n0", 32'h0000_7fff, rd)
		br(12'h104, rd);
		`CHK("n1", 32'h0, rd)
		br(12'h300, rd);
		`CHK("unmapped", 32'h0, rd)
		`CHK("hresp", 1'b0, hresp)
		`CHK("hreadyout", 1'b1, hreadyout)
	endtask : t_reset

	task automatic t_presets;
		string      f = "AAAAAABBBBBBBBBBCCCCCCAAA";
		string      lo = "0001110000011111000111000";
		string      ii = "0110111001110011111111011";
		string      dr = "0100100101001010010010011";
		string      nb = "3663660446604466044044255";
		logic [9:0] e;
		for (int p = 1; p <= 25; p++) begin
			bw(12'h000, 32'(p));
			br(12'h004, rd);
			e = {p == 25, p >= 23, dr[p-1] == "1", 3'(nb[p-1] - "0"),
				ii[p-1] == "1", lo[p-1] == "1", 2'(f[p-1] - "A")};
			`CHK("status", e, rd[9:0])
			`CHK("filter", e[1:0], interp_filter)
		end
	endtask : t_presets

	task automatic t_stream;
		bw(12'h100, 32'h4000);
		bw(12'h184, 32'h4000);
		bw(12'h000, 32'h007);
		bw(12'h000, 32'h107);
		send(16'h1000, 16'h2000);
		wait_out(1);
		`CHK("left", 16'h0800, sl)
		`CHK("right", 16'h1000, sr)
		bw(12'h000, 32'h00c);
		bw(12'h000, 32'h10c);
		send(16'h1000, 16'h2000);
		wait_out(2);
		`CHK("left", 16'h0800, sl)
		`CHK("right", 16'h0000, sr)
	endtask : t_stream

	task automatic t_chain(input logic [4:0] p, input logic [15:0] l, r,
		input logic [15:0] el, er, input int n);
		bw(12'h000, 32'(p));
		bw(12'h000, 32'h100 | 32'(p));
		send(l, r);
		wait_out(n);
		`CHK("chain left", el, sl)
		`CHK("chain right", er, sr)
	endtask : t_chain

	task automatic t_chains;
		t_chain(5'h01, 16'h1000, 16'h2000, 16'h0ffd, 16'h1ffd, 3);
		t_chain(5'h03, 16'h1000, 16'h2000, 16'h07fa, 16'h0ffa, 4);
		t_chain(5'h08, 16'h7000, 16'h0000, 16'h4bff, 16'h0000, 5);
		t_chain(5'h17, 16'h1000, 16'h2000, 16'h07fe, 16'h27fe, 6);
	endtask : t_chains

	task automatic t_refuse;
		bw(12'h100, 32'h1234);
		br(12'h100, rd);
		`CHK("locked", 32'h0, rd)
		br(12'h004, rd);
		`CHK("refused", 1'b1, rd[16])
		bw(12'h004, 32'h0001_0000);
		br(12'h004, rd);
		`CHK("cleared", 1'b0, rd[16])
		bw(12'h000, 32'h30c);
		br(12'h100, rd);
		`CHK("adapt", 32'h4000, rd)
	endtask : t_refuse

	task automatic t_buffer;
		stall <= 1'b1;
		repeat (3) send(16'h2000, 16'h0);
		repeat (30) @(posedge hclk);
		`CHK("in_ready", 1'b0, in_ready)
		`CHK("out_valid", 1'b1, out_valid)
		stall <= 1'b0;
		wait_out(9);
		`CHK("left", 16'h1000, sl)
	endtask : t_buffer

	task automatic wrap_up;
		$display("failures %0d of %0d checks", failures, cmp_count);
		if (failures == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : wrap_up

	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_presets();
		t_stream();
		t_chains();
		t_refuse();
		t_buffer();
		wrap_up();
	end
endmodule : dpc_chain_test
`default_nettype wire
